// file: bench/ebt_timer_tb.sv
// Purpose: self-checking bench for the eight-bit capture/compare timer
// Assumes: tick held high, so every cycle is a tick unless a test drops it
// Notes: a small count model predicts count, compare outputs and pending flags
`timescale 1ns/1ps
`default_nettype none
module ebt_timer_tb
   import ebt_pkg::*;
;
   logic clock, nrst, clk_en, tick, wr, rd, irq, mdn;
   logic [1:0] cap_in, cmp_out, mmode, mo;
   logic [7:0] addr, wdata, rdata, v, v1, mcnt, mtop;
   logic [2:0] mpend;
   logic [7:0] mval [2];
   logic [2:0] mact [2];
   logic [7:0] ta [8] = '{ADR_A1_SETUP, ADR_A1_VALUE, ADR_B_COUNT, ADR_B_CTL, ADR_B0_SETUP,
      ADR_B0_VALUE, ADR_PENDING, 8'h80};
   logic [7:0] te [8] = '{RST_SETUP, RST_VALUE, RST_COUNT, RST_CTL, RST_SETUP, RST_VALUE,
      {5'h00, RST_PENDING}, 8'h00};
   int bad_count, checks_done;

   // clock enable driven here so the capture test can freeze the block briefly
   ebt_timer dut (
      .clock(clock),
      .nrst(nrst),
      .clk_en(clk_en),
      .tick(tick),
      .cap_in(cap_in),
      .addr(addr),
      .wdata(wdata),
      .wr(wr),
      .rd(rd),
      .rdata(rdata),
      .cmp_out(cmp_out),
      .irq(irq)
   );

   // 250 MHz system clock
   initial
   begin
      clock = 1'b0;
      forever #2 clock = ~clock;
   end

   task check(input string n, input logic [7:0] s, input logic [7:0] e);
      checks_done++;
      if (s !== e)
      begin
         bad_count++;
         $display("[ERR] %s expected %h seen %h", n, e, s);
      end
   endtask

   task close_out;
      $display("counts: %0d checks, %0d mismatches", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   task do_reset;
      // callers may come back off the edge after a read; reset only at an edge
      @(posedge clock);
      nrst <= 1'b0;
      repeat (8) @(posedge clock);
      nrst <= 1'b1;
   endtask

   // register port: strobe for one cycle, read data the cycle after
   task wreg(input logic [7:0] a, input logic [7:0] d);
      @(posedge clock);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clock);
      wr <= 1'b0;
   endtask

   task rreg(input logic [7:0] a, output logic [7:0] d);
      @(posedge clock);
      addr <= a;
      rd <= 1'b1;
      @(posedge clock);
      rd <= 1'b0;
      #1;
      d = rdata;
   endtask

   // one counter step of the model, with channel actions and flags
   task mstep;
      logic [7:0] n;
      logic up, h, x;
      n = mcnt + 8'h01;
      if (mmode == MODE_DOWN)
         n = (mcnt == 8'h00) ? 8'h00 : mcnt - 8'h01;
      if (mmode == MODE_MOD && mcnt >= mtop)
         n = 8'h00;
      // up/down wraps only when it leaves zero after coming down, not at start
      if ((mmode == MODE_FREE && mcnt == 8'hff) || (mmode == MODE_MOD && mcnt >= mtop) ||
         (mmode == MODE_DOWN && mcnt == 8'h01) || (mmode == MODE_UPDN && mcnt == 8'h00 && mdn))
         mpend[0] = 1'b1;
      if (mmode == MODE_UPDN)
      begin
         if (mcnt == mtop)
            mdn = 1'b1;
         if (mcnt == 8'h00)
            mdn = 1'b0;
         n = mdn ? mcnt - 8'h01 : mcnt + 8'h01;
      end
      up = (mmode == MODE_UPDN) ? !mdn : (mmode != MODE_DOWN);
      for (int i = 0; i < 2; i++)
      begin
         h = (n == mval[i]);
         x = (i == 1) ? (n == mtop) : (n == 8'h00);
         if (h)
            mpend[i + 1] = 1'b1;
         case (mact[i])
            ACT_SET: if (h) mo[i] = 1'b1;
            ACT_CLEAR: if (h) mo[i] = 1'b0;
            ACT_TOGGLE: if (h) mo[i] = !mo[i];
            ACT_SET_UP, ACT_CLR_UP:
            begin
               if (h && up)
                  mo[i] = (mact[i] == ACT_SET_UP);
               else if ((mmode == MODE_UPDN) ? (h && !up) : (n == 8'h00))
                  mo[i] = (mact[i] == ACT_CLR_UP);
            end
            default:
            begin
               if (h)
                  mo[i] = (mact[i] == ACT_SET_AUX);
               else if (x)
                  mo[i] = (mact[i] == ACT_CLR_AUX);
            end
         endcase
      end
      mcnt = n;
   endtask

   // fresh reset, both channels compare, then count; low action bit picks enables
   task run(input logic [1:0] md, input logic [7:0] c1, input logic [2:0] a0,
      input logic [2:0] a1, input int reads);
      do_reset;
      mmode = md;
      mtop = 8'h03;
      mval[0] = mtop;
      mval[1] = c1;
      mact[0] = a0;
      mact[1] = a1;
      mo = 2'b00;
      mpend = 3'h0;
      mdn = 1'b0;
      mcnt = (md == MODE_DOWN) ? mtop : 8'h00;
      wreg(ADR_B0_VALUE, mtop);
      wreg(ADR_A1_VALUE, c1);
      wreg(ADR_B0_SETUP, {1'b0, a0[0], a0, 3'b100});
      wreg(ADR_A1_SETUP, {1'b0, a1[0], a1, 3'b100});
      // down mode loads from the channel 0 value only with clear low
      wreg(ADR_B_CTL, {4'b0001, a0[0], md != MODE_DOWN, md});
      repeat (reads)
      begin
         mstep;
         rreg(ADR_B_COUNT, v);
         check("count", v, mcnt);
         mstep;
         check("outputs", {6'h00, cmp_out}, {6'h00, mo});
      end
      mstep;
      rreg(ADR_PENDING, v);
      check("pending", v, {5'h00, mpend});
      check("irq", {7'h00, irq}, {7'h00, |(mpend & {a1[0], a0[0], a0[0]})});
      $display("test mode %0d actions %0d %0d done", md, a0, a1);
   endtask

   // hang guard
   initial
   begin
      repeat (100000) @(posedge clock);
      bad_count++;
      close_out;
   end

   initial
   begin
      bad_count = 0;
      checks_done = 0;
      nrst = 1'b0;
      tick = 1'b1;
      clk_en = 1'b1;
      cap_in = 2'b00;
      addr = 8'h00;
      wdata = 8'h00;
      wr = 1'b0;
      rd = 1'b0;
      do_reset;
      // writes to the count and to an unmapped place must leave no trace
      wreg(ADR_B_COUNT, 8'h77);
      wreg(8'h80, 8'hff);
      for (int i = 0; i < 8; i++)
      begin
         rreg(ta[i], v);
         check("reset value", v, te[i]);
      end
      $display("test reset values done");
      // prescaler: over 3 divided periods the count moves by exactly 3
      for (int d = 0; d < 8; d++)
      begin
         wreg(ADR_B_CTL, {d[2:0], 5'h18});
         rreg(ADR_B_COUNT, v1);
         repeat (3 * (1 << d) - 2) @(posedge clock);
         rreg(ADR_B_COUNT, v);
         check("prescale", v - v1, 8'h03);
      end
      @(posedge clock);
      tick <= 1'b0;
      rreg(ADR_B_COUNT, v1);
      repeat (4) @(posedge clock);
      rreg(ADR_B_COUNT, v);
      check("no tick", v - v1, 8'h00);
      @(posedge clock);
      tick <= 1'b1;
      $display("test prescaler done");
      run(MODE_MOD, 8'h01, ACT_SET, ACT_TOGGLE, 6);
      run(MODE_MOD, 8'h02, ACT_TOGGLE, ACT_CLEAR, 6);
      run(MODE_MOD, 8'h01, ACT_SET_UP, ACT_CLR_UP, 6);
      run(MODE_UPDN, 8'h02, ACT_CLR_UP, ACT_SET_UP, 6);
      run(MODE_UPDN, 8'h01, ACT_SET_AUX, ACT_SET_AUX, 6);
      run(MODE_FREE, 8'h02, ACT_CLR_AUX, ACT_CLR_AUX, 4);
      run(MODE_DOWN, 8'h02, ACT_SET_UP, ACT_SET, 1);
      // capture: count a few steps, then freeze it so captured values are known
      do_reset;
      mmode = MODE_FREE;
      mcnt = 8'h00;
      mval[0] = 8'hff;
      mval[1] = 8'hff;
      wreg(ADR_B_CTL, 8'h1c);
      repeat (5)
      begin
         @(posedge clock);
         mstep;
      end
      // four frozen edges must not move the count, or the held count is off
      clk_en <= 1'b0;
      repeat (4) @(posedge clock);
      clk_en <= 1'b1;
      mstep;
      wreg(ADR_B_CTL, 8'h08);
      rreg(ADR_B_COUNT, v);
      check("held count", v, mcnt);
      wreg(ADR_A1_SETUP, 8'h07);
      wreg(ADR_A1_VALUE, 8'h55);
      for (int e = 0; e < 4; e++)
      begin
         for (int k = 0; k < 2; k++)
         begin
            wreg(ADR_B0_SETUP, {6'h00, e[1:0]});
            wreg(ADR_B0_VALUE, 8'haa);
            wreg(ADR_PENDING, 8'h00);
            cap_in <= (k == 0) ? 2'b11 : 2'b00;
            repeat (6) @(posedge clock);
            rreg(ADR_B0_VALUE, v);
            check("capture", v, e[k] ? mcnt : 8'haa);
            rreg(ADR_PENDING, v);
            check("capture flag", v, {6'h00, e[k], 1'b0});
            rreg(ADR_A1_VALUE, v);
            check("compare channel", v, 8'h55);
         end
      end
      $display("test capture done");
      wreg(ADR_B_CTL, 8'h0c);
      rreg(ADR_B_COUNT, v);
      check("cleared count", v, 8'h00);
      rreg(ADR_B_CTL, v);
      check("clear bit", v, 8'h08);
      $display("test clear done");
      close_out;
   end
endmodule
`default_nettype wire

// file: logic/ebt_pkg.sv
// Purpose: shared constants and carriers of the eight-bit capture/compare timer
// Assumes: byte-wide register port, offsets are plain byte addresses
// Notes: setup and control bytes travel as packed structs
`default_nettype none
package ebt_pkg;
   // register offsets
   localparam logic [7:0] ADR_A1_SETUP = 8'hce;
   localparam logic [7:0] ADR_A1_VALUE = 8'hcf;
   localparam logic [7:0] ADR_B_COUNT = 8'hea;
   localparam logic [7:0] ADR_B_CTL = 8'heb;
   localparam logic [7:0] ADR_B0_SETUP = 8'hec;
   localparam logic [7:0] ADR_B0_VALUE = 8'hed;
   localparam logic [7:0] ADR_PENDING = 8'hf0;
   // reset values
   localparam logic [7:0] RST_CTL = 8'h08;
   localparam logic [7:0] RST_SETUP = 8'h40;
   localparam logic [7:0] RST_VALUE = 8'h00;
   localparam logic [7:0] RST_COUNT = 8'h00;
   localparam logic [2:0] RST_PENDING = 3'h0;
   // field positions
   localparam int CTL_CLR_BIT = 2;
   localparam int PEND_WRAP_BIT = 0;
   localparam int PEND_CH0_BIT = 1;
   localparam int PEND_CH1_BIT = 2;
   // counting modes
   localparam logic [1:0] MODE_FREE = 2'h0;
   localparam logic [1:0] MODE_DOWN = 2'h1;
   localparam logic [1:0] MODE_MOD = 2'h2;
   localparam logic [1:0] MODE_UPDN = 2'h3;
   // output actions
   localparam logic [2:0] ACT_SET = 3'h0;
   localparam logic [2:0] ACT_CLEAR = 3'h1;
   localparam logic [2:0] ACT_TOGGLE = 3'h2;
   localparam logic [2:0] ACT_SET_UP = 3'h3;
   localparam logic [2:0] ACT_CLR_UP = 3'h4;
   localparam logic [2:0] ACT_SET_AUX = 3'h5;
   localparam logic [2:0] ACT_CLR_AUX = 3'h6;
   // capture edges and counter top value
   localparam logic [1:0] EDGE_RISE = 2'h1;
   localparam logic [1:0] EDGE_FALL = 2'h2;
   localparam logic [1:0] EDGE_BOTH = 2'h3;
   localparam logic [7:0] COUNT_TOP = 8'hff;

   typedef struct packed {
      logic spare;
      logic channel_irq_enable;
      logic [2:0] output_action_select;
      logic cmp_mode;
      logic [1:0] edge_trigger_select;
   } ebt_setup_t;

   typedef struct packed {
      logic [2:0] divider;
      logic run;
      logic wrap_irq_enable;
      logic counter_zero_strobe;
      logic [1:0] mode;
   } ebt_ctl_t;
endpackage
`default_nettype wire

// file: logic/ebt_timer.sv
// Purpose: eight-bit timer with prescaler, four counting modes and two capture/compare channels
// Assumes: tick comes from clock control on this clock; capture pins are asynchronous
// Notes: registers sit at their byte offsets on a plain strobe port
//
// The strobed register port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
// How it works
// - counter steps only on a tick divided by two to the divider field power
// - run bit one counts, zero holds the count; run resets to zero
// - writing one to the clear bit zeroes the counter; bit reads zero
// - mode 00 counts 0 to 255 and wraps to zero forever
// - mode 01 counts down from channel 0 value to zero
// - mode 10 counts 0 up to channel 0 value then restarts at zero
// - mode 11 counts up to channel 0 value then back down, repeating
// - present count is a read-only register resetting to zero
// - per-channel enable, reset one, lets channel events request an interrupt
// - action 000 drives output high on compare match
// - action 001 drives output low on compare match
// - action 010 toggles output on each compare match
// - action 011 sets on upward match, clears at zero (in mode 11 on downward match instead)
// - action 100 clears on upward match, sets at zero (in mode 11 on downward match instead)
// - channel 1 action 101 sets on own match, clears on channel 0 match
// - channel 1 action 110 clears on own match, sets on channel 0 match
// - channel 0 action 101 sets on match, clears at count zero
// - channel 0 action 110 clears on match, sets at zero; 111 unused
// - channel mode bit picks capture at zero (reset) or compare at one
// - capture edge field: none, rising, falling or both edges
// - each channel has a read/write value register resetting to zero
// - pending flags per event, cleared only by writing zero
module ebt_timer
   import ebt_pkg::*;
(
   input wire logic clock, // system clock
   input wire logic nrst, // async reset, active low
   input wire logic clk_en, // freezes all state while low
   input wire logic tick, // global tick enable from clock control
   input wire logic [1:0] cap_in, // capture pins, asynchronous
   input wire logic [7:0] addr, // register address
   input wire logic [7:0] wdata, // write data
   input wire logic wr, // write strobe
   input wire logic rd, // read strobe
   output logic [7:0] rdata, // read data, cycle after rd
   output logic [1:0] cmp_out, // channel outputs
   output logic irq // enabled pending event present
);
   ebt_ctl_t ctl_q, ctl_d;
   ebt_setup_t su_q [2];
   ebt_setup_t su_d [2];
   logic [7:0] cc_q [2];
   logic [7:0] cc_d [2];
   logic [7:0] cnt_q, cnt_d, cnt_n, rdata_q, rdata_d;
   logic [6:0] presc_q, presc_d, pmask;
   logic dir_q, dir_d, up_step, step, ovf_ev, ctl_wr, irq_q, irq_d;
   logic [1:0] s1_q, s2_q, s3_q, out_q, out_d, mt, cap_ev, ch_ev, aux;
   logic [2:0] pend_q, pend_d;

   // next output level from action code; own match beats the secondary event
   function automatic logic next_out(input logic [2:0] act, input logic cur,
                                     input logic hit, input logic up,
                                     input logic updn, input logic zero,
                                     input logic other);
      next_out = cur;
      if (hit)
      begin
         case (act)
            ACT_SET: next_out = 1'b1;
            ACT_CLEAR: next_out = 1'b0;
            ACT_TOGGLE: next_out = ~cur;
            ACT_SET_UP: next_out = up ? 1'b1 : (updn ? 1'b0 : cur);
            ACT_CLR_UP: next_out = up ? 1'b0 : (updn ? 1'b1 : cur);
            ACT_SET_AUX: next_out = 1'b1;
            ACT_CLR_AUX: next_out = 1'b0;
            default: next_out = cur;
         endcase
      end
      else
      begin
         case (act)
            ACT_SET_UP: next_out = (!updn && zero) ? 1'b0 : cur;
            ACT_CLR_UP: next_out = (!updn && zero) ? 1'b1 : cur;
            ACT_SET_AUX: next_out = other ? 1'b0 : cur;
            ACT_CLR_AUX: next_out = other ? 1'b1 : cur;
            default: next_out = cur;
         endcase
      end
   endfunction

   // all next-state logic: software access first, hardware events after
   always_comb
   begin
      ctl_d = ctl_q;
      su_d = su_q;
      cc_d = cc_q;
      cnt_d = cnt_q;
      dir_d = dir_q;
      presc_d = presc_q;
      out_d = out_q;
      rdata_d = 8'h00;
      cnt_n = cnt_q;
      ovf_ev = 1'b0;
      up_step = 1'b0;
      ctl_wr = wr && (addr == ADR_B_CTL);
      // prescaler runs only while started so a stopped timer loses no phase
      pmask = 7'((8'h01 << ctl_q.divider) - 8'h01);
      step = 1'b0;
      if (ctl_q.run && tick)
      begin
         presc_d = presc_q + 7'h01;
         step = ((presc_q & pmask) == pmask);
      end
      // one counting step per prescaled tick
      case (ctl_q.mode)
         MODE_FREE:
         begin
            cnt_n = cnt_q + 8'h01;
            ovf_ev = (cnt_q == COUNT_TOP);
            up_step = 1'b1;
         end
         MODE_DOWN:
         begin
            cnt_n = (cnt_q == 8'h00) ? 8'h00 : cnt_q - 8'h01;
            ovf_ev = (cnt_q == 8'h01);
         end
         MODE_MOD:
         begin
            cnt_n = (cnt_q >= cc_q[0]) ? 8'h00 : cnt_q + 8'h01;
            ovf_ev = (cnt_q >= cc_q[0]);
            up_step = 1'b1;
         end
         MODE_UPDN:
         begin
            up_step = !dir_q;
            if (!dir_q && cnt_q >= cc_q[0])
            begin
               cnt_n = (cnt_q == 8'h00) ? 8'h00 : cnt_q - 8'h01;
               up_step = 1'b0;
            end
            else if (dir_q && cnt_q == 8'h00)
            begin
               cnt_n = 8'h01;
               ovf_ev = 1'b1;
               up_step = 1'b1;
            end
            else
               cnt_n = dir_q ? cnt_q - 8'h01 : cnt_q + 8'h01;
         end
         default: cnt_n = cnt_q;
      endcase
      // a control write takes the step's place in its cycle
      step = step && !ctl_wr;
      ovf_ev = ovf_ev && step;
      if (ctl_wr)
      begin
         ctl_d = ebt_ctl_t'({wdata[7:3], 1'b0, wdata[1:0]});
         if (wdata[CTL_CLR_BIT])
         begin
            cnt_d = 8'h00;
            dir_d = 1'b0;
         end
         else if (wdata[1:0] == MODE_DOWN)
            cnt_d = cc_q[0];
      end
      else if (step)
      begin
         cnt_d = cnt_n;
         if (ctl_q.mode == MODE_UPDN)
            dir_d = !up_step;
         else
            dir_d = 1'b0;
      end
      // channel compare and capture
      aux[0] = step && (cnt_n == 8'h00);
      aux[1] = step && (cnt_n == cc_q[0]);
      for (int i = 0; i < 2; i++)
      begin
         if (wr && addr == (i == 0 ? ADR_B0_SETUP : ADR_A1_SETUP))
            su_d[i] = ebt_setup_t'({1'b0, wdata[6:0]});
         if (wr && addr == (i == 0 ? ADR_B0_VALUE : ADR_A1_VALUE))
            cc_d[i] = wdata;
         mt[i] = step && su_q[i].cmp_mode && (cnt_n == cc_q[i]);
         case (su_q[i].edge_trigger_select)
            EDGE_RISE: cap_ev[i] = s2_q[i] && !s3_q[i];
            EDGE_FALL: cap_ev[i] = !s2_q[i] && s3_q[i];
            EDGE_BOTH: cap_ev[i] = s2_q[i] ^ s3_q[i];
            default: cap_ev[i] = 1'b0;
         endcase
         cap_ev[i] = cap_ev[i] && !su_q[i].cmp_mode;
         if (cap_ev[i])
            cc_d[i] = cnt_q;
         ch_ev[i] = mt[i] || cap_ev[i];
         if (su_q[i].cmp_mode)
            out_d[i] = next_out(su_q[i].output_action_select, out_q[i], mt[i], up_step,
                                ctl_q.mode == MODE_UPDN, aux[0], aux[i]);
      end
      // pending flags: writing zero clears, a new event in the same cycle wins
      pend_d = pend_q;
      if (wr && addr == ADR_PENDING)
         pend_d = pend_q & wdata[2:0];
      pend_d[PEND_WRAP_BIT] = pend_d[PEND_WRAP_BIT] | ovf_ev;
      pend_d[PEND_CH0_BIT] = pend_d[PEND_CH0_BIT] | ch_ev[0];
      pend_d[PEND_CH1_BIT] = pend_d[PEND_CH1_BIT] | ch_ev[1];
      irq_d = (pend_q[PEND_WRAP_BIT] && ctl_q.wrap_irq_enable)
         || (pend_q[PEND_CH0_BIT] && su_q[0].channel_irq_enable)
         || (pend_q[PEND_CH1_BIT] && su_q[1].channel_irq_enable);
      // read mux, data valid only in the cycle after the strobe
      if (rd)
      begin
         case (addr)
            ADR_B_COUNT: rdata_d = cnt_q;
            ADR_B_CTL: rdata_d = ctl_q;
            ADR_B0_SETUP: rdata_d = su_q[0];
            ADR_B0_VALUE: rdata_d = cc_q[0];
            ADR_A1_SETUP: rdata_d = su_q[1];
            ADR_A1_VALUE: rdata_d = cc_q[1];
            ADR_PENDING: rdata_d = {5'h00, pend_q};
            default: rdata_d = 8'h00;
         endcase
      end
   end

   // state registers; pins pass s1 and s2 before any logic looks at them
   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst)
      begin
         ctl_q <= ebt_ctl_t'(RST_CTL);
         su_q[0] <= ebt_setup_t'(RST_SETUP);
         su_q[1] <= ebt_setup_t'(RST_SETUP);
         cc_q[0] <= RST_VALUE;
         cc_q[1] <= RST_VALUE;
         cnt_q <= RST_COUNT;
         dir_q <= 1'b0;
         presc_q <= 7'h00;
         out_q <= 2'h0;
         pend_q <= RST_PENDING;
         rdata_q <= 8'h00;
         irq_q <= 1'b0;
         s1_q <= 2'h0;
         s2_q <= 2'h0;
         s3_q <= 2'h0;
      end
      else if (clk_en)
      begin
         ctl_q <= ctl_d;
         su_q <= su_d;
         cc_q <= cc_d;
         cnt_q <= cnt_d;
         dir_q <= dir_d;
         presc_q <= presc_d;
         out_q <= out_d;
         pend_q <= pend_d;
         rdata_q <= rdata_d;
         irq_q <= irq_d;
         s1_q <= cap_in;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end

   assign rdata = rdata_q;
   assign cmp_out = out_q;
   assign irq = irq_q;

   // checks on the design's own behaviour
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!nrst);

   property p_prescale;
      clk_en && !ctl_wr && !(ctl_q.run && tick && ((presc_q & pmask) == pmask))
         |=> cnt_q == $past(cnt_q);
   endproperty
   a_prescale: assert property (p_prescale) else $error("count moved without tick");

   property p_hold;
      clk_en && !ctl_q.run && !ctl_wr ##1 clk_en && !ctl_q.run && !ctl_wr
         |=> cnt_q == $past(cnt_q, 2);
   endproperty
   a_hold: assert property (p_hold) else $error("stopped counter moved");

   property p_clear;
      clk_en && ctl_wr && wdata[CTL_CLR_BIT] |=> cnt_q == 8'h00 && !ctl_q.counter_zero_strobe;
   endproperty
   a_clear: assert property (p_clear) else $error("clear did not zero counter");

   property p_free;
      clk_en && step && ctl_q.mode == MODE_FREE |=> cnt_q == 8'($past(cnt_q) + 8'h01);
   endproperty
   a_free: assert property (p_free) else $error("free run step wrong");

   property p_down;
      clk_en && step && ctl_q.mode == MODE_DOWN && cnt_q != 8'h00
         |=> cnt_q == 8'($past(cnt_q) - 8'h01);
   endproperty
   a_down: assert property (p_down) else $error("down step wrong");

   property p_modulo;
      clk_en && step && ctl_q.mode == MODE_MOD && cnt_q == cc_q[0] |=> cnt_q == 8'h00;
   endproperty
   a_modulo: assert property (p_modulo) else $error("modulo did not restart");

   property p_updn;
      clk_en && step && ctl_q.mode == MODE_UPDN && cnt_q == cc_q[0] && cnt_q != 8'h00
         && !dir_q |=> dir_q && cnt_q == 8'($past(cnt_q) - 8'h01);
   endproperty
   a_updn: assert property (p_updn) else $error("up/down did not turn");

   property p_read;
      rd && clk_en && addr == ADR_B_COUNT |=> rdata == $past(cnt_q);
   endproperty
   a_read: assert property (p_read) else $error("count read wrong");

   property p_irq;
      clk_en |=> irq == ($past(pend_q[PEND_CH0_BIT] && su_q[0].channel_irq_enable)
         || $past(pend_q[PEND_CH1_BIT] && su_q[1].channel_irq_enable)
         || $past(pend_q[PEND_WRAP_BIT] && ctl_q.wrap_irq_enable));
   endproperty
   a_irq: assert property (p_irq) else $error("request not gated by enables");

   property p_set;
      clk_en && mt[0] && su_q[0].output_action_select == ACT_SET |=> cmp_out[0];
   endproperty
   a_set: assert property (p_set) else $error("set on compare failed");

   property p_pend;
      pend_q[PEND_WRAP_BIT] && !(wr && addr == ADR_PENDING) |=> pend_q[PEND_WRAP_BIT];
   endproperty
   a_pend: assert property (p_pend) else $error("pending flag dropped");

   property p_cap;
      clk_en && cap_ev[0] |=> cc_q[0] == $past(cnt_q) && pend_q[PEND_CH0_BIT];
   endproperty
   a_cap: assert property (p_cap) else $error("capture lost");

   c_wrap: cover property (clk_en && ovf_ev);
   c_cap: cover property (clk_en && cap_ev[1]);
   c_toggle: cover property (clk_en && mt[1] && su_q[1].output_action_select == ACT_TOGGLE);
endmodule
`default_nettype wire
